// [test/tb_wake_timer_block.sv]
// self-checking bench for the wake-up timer block and the rf timer tail
`timescale 1ns/1ps
module tb_wake_timer_block;
   logic mclk; // system clock
   logic rst_n; // async reset, active low
   logic [7:0] addr; // register address
   logic [7:0] wdata; // write data
   logic wr_en; // write strobe
   logic rd_en; // read strobe
   logic lfo_tick; // oscillator pulse
   logic rf_timer_tick; // rf timer clock pulse
   logic rf_timer_start; // rf timer start pulse
   logic trim_done; // trim finished pulse
   logic card_present; // detector result
   logic [7:0] rdata; // read data
   logic wake_irq_set, card_irq_set, trim_start, field_on; // event outputs
   logic wake_request, power_down_request, rf_timer_underflow; // event outputs
   int n_errors = 0; // mismatches
   int compares = 0; // comparisons made
   int n_pulse[6] = '{default: 0}; // seen: irq, wake, trim, card, down, rf
   int e_pulse[6] = '{default: 0}; // model counts, same order
   logic [15:0] rl; // wake reload in use
   logic [15:0] rf; // rf reload in use
   int k; // loop index
   int d; // divide ratio
   // automatic sequence cases: control byte and card result; trimming never borrows the rf timer
   logic [7:0] ctl_tab [6] = '{8'hE4, 8'hE0, 8'hD4, 8'hD4, 8'hF4, 8'hD0};
   logic card_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [7:0] rw_tab [4] = '{8'h1F, 8'h20, 8'h24, 8'h25}; // writable bytes
   logic [7:0] ro_tab [4] = '{8'h21, 8'h22, 8'h26, 8'h27}; // count bytes

   wake_timer_block wake_timer_block_i (.mclk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .lfo_tick,
      .rf_timer_tick, .rf_timer_start, .trim_done, .card_present, .wake_irq_set, .card_irq_set, .trim_start,
      .field_on, .wake_request, .power_down_request, .rf_timer_underflow);

   // clock, 5 ns period
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // pulse counters; outputs are one-cycle pulses so each high cycle is one event
   always @(posedge mclk) begin
      n_pulse[0] <= n_pulse[0] + (wake_irq_set === 1'b1);
      n_pulse[1] <= n_pulse[1] + (wake_request === 1'b1);
      n_pulse[2] <= n_pulse[2] + (trim_start === 1'b1);
      n_pulse[3] <= n_pulse[3] + (card_irq_set === 1'b1);
      n_pulse[4] <= n_pulse[4] + (power_down_request === 1'b1);
      n_pulse[5] <= n_pulse[5] + (rf_timer_underflow === 1'b1);
   end

   // verdict and end of run
   task automatic complete_run();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // single comparison point
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one-cycle write
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr

   // read; data stands only in the cycle after the strobe
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      check({8'h00, rdata}, {8'h00, e});
   endtask : chk_rd

   // wake count, only read while no tick is pending so bytes cannot tear
   task automatic chk_cnt(input logic [15:0] e);
      chk_rd(wake_timer_pkg::ADDR_WAKE_COUNT_HIGH, e[15:8]);
      chk_rd(wake_timer_pkg::ADDR_WAKE_COUNT_LOW, e[7:0]);
   endtask : chk_cnt

   task automatic chk_pulses();
      for (int i = 0; i < 6; i++) check(16'(n_pulse[i]), 16'(e_pulse[i]));
   endtask : chk_pulses

   // n oscillator pulses, then let the prescaler and counter settle
   task automatic lfo(input int n);
      repeat (n) begin
         @(posedge mclk);
         lfo_tick <= 1'b1;
         @(posedge mclk);
         lfo_tick <= 1'b0;
      end
      repeat (3) @(posedge mclk);
   endtask : lfo

   // one-cycle pulse: 0 trim done, 1 rf tick, 2 rf start
   task automatic pulse(input int s);
      @(posedge mclk);
      trim_done <= (s == 0);
      rf_timer_tick <= (s == 1);
      rf_timer_start <= (s == 2);
      @(posedge mclk);
      trim_done <= 1'b0;
      rf_timer_tick <= 1'b0;
      rf_timer_start <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : pulse

   // bounded wait for the field level
   task automatic wait_field(input logic lvl);
      for (int i = 0; i < 40 && field_on !== lvl; i++) @(posedge mclk);
      check({15'h0000, field_on}, {15'h0000, lvl});
   endtask : wait_field

   // one underflow through trim and/or card detection; model tallies pulses
   task automatic run_seq(input logic [7:0] c, input logic cp);
      card_present <= cp;
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, c);
      lfo(1);
      e_pulse[0]++;
      e_pulse[1] += c[2];
      e_pulse[2] += c[5];
      if (c[5]) pulse(0);
      if (c[4]) begin
         wait_field(1'b1);
         chk_rd(wake_timer_pkg::ADDR_RF_COUNT_HIGH, 8'h00);
         chk_rd(wake_timer_pkg::ADDR_RF_COUNT_LOW, rf[7:0]);
         repeat (rf) pulse(1);
         wait_field(1'b0);
         e_pulse[5]++;
         e_pulse[3] += cp;
      end
      // with auto wake set: power down after trim alone or after a miss, never after a found card
      e_pulse[4] += c[2] & ~(c[4] & cp);
      repeat (3) @(posedge mclk);
      chk_pulses();
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, {c[4], 1'b0, c[5:0]});
      chk_cnt(c[4] ? 16'h0001 : 16'h0000);
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h40);
   endtask : run_seq

   // watchdog, far beyond the well under a thousand cycles the tests need
   initial begin
      #100000;
      n_errors++;
      complete_run();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      lfo_tick = 1'b0;
      rf_timer_tick = 1'b0;
      rf_timer_start = 1'b0;
      trim_done = 1'b0;
      card_present = 1'b0;
      void'($urandom(32'h4E378577));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      // reset values, one unmapped address at the end
      for (k = 8'h1F; k <= 8'h28; k++) chk_rd(k[7:0], 8'h00);
      // reload bytes hold random values, count bytes ignore writes
      for (k = 0; k < 4; k++) begin
         rl[7:0] = 8'($urandom);
         wr(rw_tab[k], rl[7:0]);
         chk_rd(rw_tab[k], rl[7:0]);
         wr(ro_tab[k], 8'($urandom));
         chk_rd(ro_tab[k], 8'h00);
      end
      // ungated write cannot start the timer; gate reads back as 0
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'hBF);
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h3F);
      // one-shot countdown, undivided clock
      rl = 16'(3 + $urandom % 4);
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH, 8'h00);
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_LOW, rl[7:0]);
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'hC0);
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h80);
      chk_cnt(rl);
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_LOW, rl[7:0] + 8'h05);
      lfo(rl - 1);
      chk_cnt(16'h0001);
      lfo(1);
      e_pulse[0]++;
      chk_cnt(16'h0000);
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h00);
      chk_pulses();
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'hC0);
      chk_cnt(rl + 16'h0005);
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h40);
      lfo(2);
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h00);
      chk_cnt(rl + 16'h0005);
      // every clock select: one count step needs exactly the divide ratio
      for (k = 0; k < 4; k++) begin
         d = (k == 0) ? 1 : (4 << k);
         rl = {8'($urandom), 8'h05};
         wr(wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH, rl[15:8]);
         wr(wake_timer_pkg::ADDR_WAKE_RELOAD_LOW, 8'h05);
         wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'hC8 | 8'(k));
         lfo(d - 1);
         chk_cnt(rl);
         lfo(1);
         chk_cnt(rl - 16'h0001);
         wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h40);
      end
      // auto reload with auto wake
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH, 8'h00);
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_LOW, 8'h02);
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'hCC);
      lfo(2);
      e_pulse[0]++;
      e_pulse[1]++;
      chk_pulses();
      chk_cnt(16'h0002);
      chk_rd(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h8C);
      wr(wake_timer_pkg::ADDR_WAKE_CONTROL, 8'h40);
      // automatic trim and card detection cases
      rf = 16'(2 + $urandom % 3);
      wr(wake_timer_pkg::ADDR_RF_RELOAD_HIGH, 8'h00);
      wr(wake_timer_pkg::ADDR_RF_RELOAD_LOW, rf[7:0]);
      wr(wake_timer_pkg::ADDR_WAKE_RELOAD_LOW, 8'h01);
      for (k = 0; k < 6; k++) run_seq(ctl_tab[k], card_tab[k]);
      // external start; counts read only while no card reception runs
      rf = {8'($urandom), 8'h03};
      wr(wake_timer_pkg::ADDR_RF_RELOAD_HIGH, rf[15:8]);
      wr(wake_timer_pkg::ADDR_RF_RELOAD_LOW, 8'h03);
      pulse(2);
      chk_rd(wake_timer_pkg::ADDR_RF_COUNT_HIGH, rf[15:8]);
      chk_rd(wake_timer_pkg::ADDR_RF_COUNT_LOW, 8'h03);
      wr(wake_timer_pkg::ADDR_RF_RELOAD_HIGH, 8'h00);
      chk_rd(wake_timer_pkg::ADDR_RF_COUNT_HIGH, rf[15:8]);
      pulse(2);
      chk_rd(wake_timer_pkg::ADDR_RF_COUNT_HIGH, 8'h00);
      // one tick past zero: counter stays at zero, one underflow
      repeat (4) pulse(1);
      e_pulse[5]++;
      chk_rd(wake_timer_pkg::ADDR_RF_COUNT_LOW, 8'h00);
      chk_pulses();
      complete_run();
   end
endmodule : tb_wake_timer_block

// [verilog/lfo_prescaler.sv]
// divides oscillator ticks by 1, 8, 16 or 32 for the wake-up timer
`timescale 1ns/1ps
module lfo_prescaler (
   input wire logic mclk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic clear, // restart division on a start event
   input wire logic lfo_tick, // one-cycle pulse per oscillator period
   input wire logic [1:0] sel, // clock select code
   output logic tick // one-cycle pulse per selected period
);
   logic [4:0] div_q; // ticks seen in current period
   logic [4:0] last; // terminal count for the selection
   logic tick_q; // registered output pulse

   // terminal count per selection
   always_comb begin
      unique case (sel)
         wake_timer_pkg::CLK_DIV1: last = 5'h00;
         wake_timer_pkg::CLK_DIV8: last = wake_timer_pkg::DIV8_LAST;
         wake_timer_pkg::CLK_DIV16: last = wake_timer_pkg::DIV16_LAST;
         wake_timer_pkg::CLK_DIV32: last = wake_timer_pkg::DIV32_LAST;
      endcase
   end

   // count oscillator ticks, emit one at terminal count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 5'h00;
         tick_q <= 1'b0;
      end else if (clear) begin
         // a start always begins a full period, never a partial one
         div_q <= 5'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (lfo_tick) begin
            if (div_q >= last) begin
               div_q <= 5'h00;
               tick_q <= 1'b1;
            end else begin
               div_q <= div_q + 5'h01;
            end
         end
      end
   end

   assign tick = tick_q;

   AST_DIV1_PASS: assert property (@(posedge mclk) disable iff (!rst_n)
      (lfo_tick && !clear && sel == wake_timer_pkg::CLK_DIV1) |=> tick)
      else $error("undivided select dropped a tick");
endmodule : lfo_prescaler

// [verilog/wake_timer_block.sv]
// wake-up timer with automatic trim and card detection, plus rf timer counter
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module wake_timer_block (
   input wire logic mclk, // 200 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] addr, // register byte address
   input wire logic [7:0] wdata, // register write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd_en
   input wire logic lfo_tick, // low-frequency oscillator pulse
   input wire logic rf_timer_tick, // rf timer input clock pulse
   input wire logic rf_timer_start, // external rf timer start event
   input wire logic trim_done, // trimming logic finished
   input wire logic card_present, // detector result at field end
   output logic wake_irq_set, // pulse: set the wake timer irq flag
   output logic card_irq_set, // pulse: card detected request
   output logic trim_start, // pulse: launch oscillator trimming
   output logic field_on, // level: rf field enabled for detection
   output logic wake_request, // pulse: wake the system
   output logic power_down_request, // pulse: return to power down
   output logic rf_timer_underflow // pulse: rf timer reached zero
);
   // register storage
   logic [7:0] rf_reload_hi_q; // rf timer reload high byte
   logic [7:0] rf_reload_lo_q; // rf timer reload low byte
   logic [15:0] rf_count_q; // rf timer counter
   logic rf_run_q; // rf timer counting
   logic [5:0] ctl_q; // stored control bits 5..0
   logic running_q; // wake timer running flag
   logic [7:0] wk_reload_hi_q; // wake reload high byte
   logic [7:0] wk_reload_lo_q; // wake reload low byte
   logic [15:0] wk_count_q; // wake timer counter
   logic [7:0] rdata_q; // registered read data
   wake_timer_pkg::seq_t seq_q; // automatic sequence state

   // registered outputs
   logic wake_irq_q; // irq set pulse
   logic card_irq_q; // card found pulse
   logic trim_q; // trim start pulse
   logic field_q; // field enable level
   logic wake_req_q; // wake pulse
   logic pd_req_q; // power down pulse
   logic rf_uflow_q; // rf underflow pulse

   // decoded events
   logic ctl_wr; // write to control register
   logic gate_wr; // control write with gate bit
   logic sw_start; // software start of wake timer
   logic wk_tick; // divided wake timer tick
   logic wk_uflow; // wake timer underflow this cycle
   logic rf_start; // rf timer start event
   logic rf_zero; // rf timer underflow this cycle
   logic [15:0] wk_reload; // assembled wake reload value
   logic [15:0] rf_reload; // assembled rf reload value
   logic auto_reload; // wake timer restarts after zero

   assign wk_reload = {wk_reload_hi_q, wk_reload_lo_q};
   assign rf_reload = {rf_reload_hi_q, rf_reload_lo_q};
   assign ctl_wr = wr_en && (addr == wake_timer_pkg::ADDR_WAKE_CONTROL);
   assign gate_wr = ctl_wr && wdata[wake_timer_pkg::CTL_GATE];
   assign sw_start = gate_wr && wdata[wake_timer_pkg::CTL_RUNNING];
   // detection restarts the timer with no gap even without auto reload
   assign auto_reload = ctl_q[wake_timer_pkg::CTL_AUTO_RELOAD] || ctl_q[wake_timer_pkg::CTL_AUTO_CARD];
   assign wk_uflow = running_q && wk_tick && (wk_count_q <= 16'h0001);
   assign rf_zero = rf_run_q && rf_timer_tick && (rf_count_q <= 16'h0001) && !rf_start;

   // rf timer is started from outside or by the detection sequence
   assign rf_start = rf_timer_start || (wk_uflow && seq_q == wake_timer_pkg::SEQ_IDLE &&
                     !ctl_q[wake_timer_pkg::CTL_AUTO_TRIM] && ctl_q[wake_timer_pkg::CTL_AUTO_CARD]) ||
                     (seq_q == wake_timer_pkg::SEQ_TRIM && trim_done && ctl_q[wake_timer_pkg::CTL_AUTO_CARD]);

   // selected input clock for the wake timer
   lfo_prescaler u_prescaler (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(sw_start),
      .lfo_tick(lfo_tick),
      .sel(ctl_q[wake_timer_pkg::CTL_CLK_HI:wake_timer_pkg::CTL_CLK_LO]),
      .tick(wk_tick)
   );

   // software-written reload bytes and control bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rf_reload_hi_q <= wake_timer_pkg::RESET_BYTE;
         rf_reload_lo_q <= wake_timer_pkg::RESET_BYTE;
         wk_reload_hi_q <= wake_timer_pkg::RESET_BYTE;
         wk_reload_lo_q <= wake_timer_pkg::RESET_BYTE;
         ctl_q <= wake_timer_pkg::RESET_CONTROL;
      end else if (wr_en) begin
         unique case (addr)
            wake_timer_pkg::ADDR_RF_RELOAD_HIGH: rf_reload_hi_q <= wdata;
            wake_timer_pkg::ADDR_RF_RELOAD_LOW: rf_reload_lo_q <= wdata;
            wake_timer_pkg::ADDR_WAKE_CONTROL: ctl_q <= wdata[5:0];
            wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH: wk_reload_hi_q <= wdata;
            wake_timer_pkg::ADDR_WAKE_RELOAD_LOW: wk_reload_lo_q <= wdata;
            default: begin
               // read-only and unmapped addresses ignore writes
            end
         endcase
      end
   end

   // wake timer counter and running flag
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wk_count_q <= wake_timer_pkg::RESET_COUNT;
         running_q <= 1'b0;
      end else if (gate_wr) begin
         // gated write owns the running flag; a start reloads the count
         running_q <= wdata[wake_timer_pkg::CTL_RUNNING];
         if (wdata[wake_timer_pkg::CTL_RUNNING]) begin
            wk_count_q <= wk_reload;
         end
      end else if (wk_uflow) begin
         if (auto_reload) begin
            wk_count_q <= wk_reload;
         end else begin
            wk_count_q <= 16'h0000;
            running_q <= 1'b0;
         end
      end else if (running_q && wk_tick) begin
         wk_count_q <= wk_count_q - 16'h0001;
      end
   end

   // rf timer counter, loaded only at a start event
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rf_count_q <= wake_timer_pkg::RESET_COUNT;
         rf_run_q <= 1'b0;
      end else if (rf_start) begin
         rf_count_q <= rf_reload;
         rf_run_q <= 1'b1;
      end else if (rf_zero) begin
         rf_count_q <= 16'h0000;
         rf_run_q <= 1'b0;
      end else if (rf_run_q && rf_timer_tick) begin
         rf_count_q <= rf_count_q - 16'h0001;
      end
   end

   // automatic trim and card detection sequence
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seq_q <= wake_timer_pkg::SEQ_IDLE;
         trim_q <= 1'b0;
         field_q <= 1'b0;
         card_irq_q <= 1'b0;
         pd_req_q <= 1'b0;
      end else begin
         trim_q <= 1'b0;
         card_irq_q <= 1'b0;
         pd_req_q <= 1'b0;
         unique case (seq_q)
            wake_timer_pkg::SEQ_IDLE: begin
               // an underflow during a running sequence launches nothing new
               if (wk_uflow && ctl_q[wake_timer_pkg::CTL_AUTO_TRIM]) begin
                  trim_q <= 1'b1;
                  seq_q <= wake_timer_pkg::SEQ_TRIM;
               end else if (wk_uflow && ctl_q[wake_timer_pkg::CTL_AUTO_CARD]) begin
                  field_q <= 1'b1;
                  seq_q <= wake_timer_pkg::SEQ_FIELD;
               end
            end
            wake_timer_pkg::SEQ_TRIM: begin
               if (trim_done && ctl_q[wake_timer_pkg::CTL_AUTO_CARD]) begin
                  field_q <= 1'b1;
                  seq_q <= wake_timer_pkg::SEQ_FIELD;
               end else if (trim_done) begin
                  pd_req_q <= ctl_q[wake_timer_pkg::CTL_AUTO_WAKE];
                  seq_q <= wake_timer_pkg::SEQ_IDLE;
               end
            end
            wake_timer_pkg::SEQ_FIELD: begin
               // field stays on for exactly the rf timer interval
               if (rf_zero) begin
                  field_q <= 1'b0;
                  seq_q <= wake_timer_pkg::SEQ_DECIDE;
               end
            end
            wake_timer_pkg::SEQ_DECIDE: begin
               if (card_present) begin
                  card_irq_q <= 1'b1;
               end else begin
                  pd_req_q <= ctl_q[wake_timer_pkg::CTL_AUTO_WAKE];
               end
               seq_q <= wake_timer_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // underflow side effects: irq flag set, automatic wake, rf underflow
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wake_irq_q <= 1'b0;
         wake_req_q <= 1'b0;
         rf_uflow_q <= 1'b0;
      end else begin
         wake_irq_q <= wk_uflow;
         wake_req_q <= wk_uflow && ctl_q[wake_timer_pkg::CTL_AUTO_WAKE];
         rf_uflow_q <= rf_zero;
      end
   end

   // register read port; counts are sampled live, so reads mid-reception tear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= wake_timer_pkg::RESET_BYTE;
      end else if (rd_en) begin
         unique case (addr)
            wake_timer_pkg::ADDR_RF_RELOAD_HIGH: rdata_q <= rf_reload_hi_q;
            wake_timer_pkg::ADDR_RF_RELOAD_LOW: rdata_q <= rf_reload_lo_q;
            wake_timer_pkg::ADDR_RF_COUNT_HIGH: rdata_q <= rf_count_q[15:8];
            wake_timer_pkg::ADDR_RF_COUNT_LOW: rdata_q <= rf_count_q[7:0];
            wake_timer_pkg::ADDR_WAKE_CONTROL: rdata_q <= {running_q, 1'b0, ctl_q};
            wake_timer_pkg::ADDR_WAKE_RELOAD_HIGH: rdata_q <= wk_reload_hi_q;
            wake_timer_pkg::ADDR_WAKE_RELOAD_LOW: rdata_q <= wk_reload_lo_q;
            wake_timer_pkg::ADDR_WAKE_COUNT_HIGH: rdata_q <= wk_count_q[15:8];
            wake_timer_pkg::ADDR_WAKE_COUNT_LOW: rdata_q <= wk_count_q[7:0];
            default: rdata_q <= wake_timer_pkg::RESET_BYTE;
         endcase
      end else begin
         rdata_q <= wake_timer_pkg::RESET_BYTE;
      end
   end

   // output ports straight from flops
   assign rdata = rdata_q;
   assign wake_irq_set = wake_irq_q;
   assign card_irq_set = card_irq_q;
   assign trim_start = trim_q;
   assign field_on = field_q;
   assign wake_request = wake_req_q;
   assign power_down_request = pd_req_q;
   assign rf_timer_underflow = rf_uflow_q;

   // checks on the timer behaviour
   AST_UFLOW_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
      wk_uflow |=> wake_irq_set)
      else $error("underflow did not set irq flag");

   AST_GATE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (ctl_wr && !wdata[wake_timer_pkg::CTL_GATE] && !wk_uflow) |=> $stable(running_q))
      else $error("ungated write changed running flag");

   AST_START_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
      sw_start |=> (running_q && wk_count_q == $past(wk_reload)))
      else $error("start did not load reload value");

   AST_ONESHOT_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
      (wk_uflow && !gate_wr && !auto_reload) |=> (!running_q && wk_count_q == 16'h0000))
      else $error("one-shot timer kept running");

   AST_AUTO_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n)
      (wk_uflow && !gate_wr && auto_reload) |=> (running_q && wk_count_q == $past(wk_reload)))
      else $error("auto reload failed");

   AST_DECREMENT: assert property (@(posedge mclk) disable iff (!rst_n)
      (running_q && wk_tick && !wk_uflow && !gate_wr) |=> wk_count_q == $past(wk_count_q) - 16'h0001)
      else $error("counter did not step by one");

   AST_TRIM_START: assert property (@(posedge mclk) disable iff (!rst_n)
      (wk_uflow && seq_q == wake_timer_pkg::SEQ_IDLE && ctl_q[wake_timer_pkg::CTL_AUTO_TRIM]) |=> trim_start)
      else $error("trim not started on underflow");

   AST_RF_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
      rf_start |=> rf_count_q == $past(rf_reload))
      else $error("rf timer start did not load reload");

   AST_COUNT_READ: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && addr == wake_timer_pkg::ADDR_WAKE_COUNT_HIGH) |=> rdata == $past(wk_count_q[15:8]))
      else $error("count high byte read wrong");

   AST_NO_CARD_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
      (seq_q == wake_timer_pkg::SEQ_DECIDE && !card_present && ctl_q[wake_timer_pkg::CTL_AUTO_WAKE])
      |=> (power_down_request && !card_irq_set))
      else $error("no card did not return to power down");

   AST_WAKE_REQ: assert property (@(posedge mclk) disable iff (!rst_n)
      wk_uflow |=> (wake_request == $past(ctl_q[wake_timer_pkg::CTL_AUTO_WAKE])))
      else $error("auto wake request wrong after underflow");

   AST_RF_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
      rf_zero |=> (!rf_run_q && rf_count_q == 16'h0000 && rf_timer_underflow))
      else $error("rf timer did not stop at zero");

   AST_RF_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!rf_start && !(rf_run_q && rf_timer_tick)) |=> $stable(rf_count_q))
      else $error("rf count moved without start or tick");

   AST_WAKE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!gate_wr && !(running_q && wk_tick)) |=> $stable(wk_count_q))
      else $error("wake count moved without start or tick");

   AST_FIELD_START: assert property (@(posedge mclk) disable iff (!rst_n)
      (wk_uflow && seq_q == wake_timer_pkg::SEQ_IDLE && !ctl_q[wake_timer_pkg::CTL_AUTO_TRIM] &&
       ctl_q[wake_timer_pkg::CTL_AUTO_CARD]) |=> (field_on && rf_run_q))
      else $error("card detection did not switch field on");

   AST_FIELD_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (seq_q == wake_timer_pkg::SEQ_FIELD && rf_zero) |=> (!field_on && seq_q == wake_timer_pkg::SEQ_DECIDE))
      else $error("field not switched off at rf timer end");

   AST_CARD_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
      (seq_q == wake_timer_pkg::SEQ_DECIDE && card_present) |=> (card_irq_set && !power_down_request))
      else $error("found card did not raise request");

   AST_CTL_READ: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && addr == wake_timer_pkg::ADDR_WAKE_CONTROL) |=> (!rdata[wake_timer_pkg::CTL_GATE] &&
       rdata[wake_timer_pkg::CTL_RUNNING] == $past(running_q)))
      else $error("control read shows gate or wrong running flag");

   COV_RELOAD: cover property (@(posedge mclk) disable iff (!rst_n) wk_uflow && auto_reload);
   COV_CARD: cover property (@(posedge mclk) disable iff (!rst_n) card_irq_set);
   COV_TRIM_DONE: cover property (@(posedge mclk) disable iff (!rst_n)
      seq_q == wake_timer_pkg::SEQ_TRIM && trim_done);
   COV_NO_CARD: cover property (@(posedge mclk) disable iff (!rst_n)
      seq_q == wake_timer_pkg::SEQ_DECIDE && !card_present && ctl_q[wake_timer_pkg::CTL_AUTO_WAKE]);
   COV_GATED_STOP: cover property (@(posedge mclk) disable iff (!rst_n)
      gate_wr && !wdata[wake_timer_pkg::CTL_RUNNING]);
endmodule : wake_timer_block

// [verilog/wake_timer_pkg.sv]
// constants shared by the wake-up timer block and its prescaler
package wake_timer_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_RF_RELOAD_HIGH = 8'h1F;
   localparam logic [7:0] ADDR_RF_RELOAD_LOW = 8'h20;
   localparam logic [7:0] ADDR_RF_COUNT_HIGH = 8'h21;
   localparam logic [7:0] ADDR_RF_COUNT_LOW = 8'h22;
   localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h23;
   localparam logic [7:0] ADDR_WAKE_RELOAD_HIGH = 8'h24;
   localparam logic [7:0] ADDR_WAKE_RELOAD_LOW = 8'h25;
   localparam logic [7:0] ADDR_WAKE_COUNT_HIGH = 8'h26;
   localparam logic [7:0] ADDR_WAKE_COUNT_LOW = 8'h27;

   // control register field positions
   localparam int CTL_RUNNING = 7;
   localparam int CTL_GATE = 6;
   localparam int CTL_AUTO_TRIM = 5;
   localparam int CTL_AUTO_CARD = 4;
   localparam int CTL_AUTO_RELOAD = 3;
   localparam int CTL_AUTO_WAKE = 2;
   localparam int CTL_CLK_HI = 1;
   localparam int CTL_CLK_LO = 0;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] RESET_CONTROL = 6'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;

   // clock select codes and divide ratios
   localparam logic [1:0] CLK_DIV1 = 2'h0;
   localparam logic [1:0] CLK_DIV8 = 2'h1;
   localparam logic [1:0] CLK_DIV16 = 2'h2;
   localparam logic [1:0] CLK_DIV32 = 2'h3;
   localparam logic [4:0] DIV8_LAST = 5'h07;
   localparam logic [4:0] DIV16_LAST = 5'h0F;
   localparam logic [4:0] DIV32_LAST = 5'h1F;

   // automatic sequence states
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_TRIM = 2'b01,
      SEQ_FIELD = 2'b10,
      SEQ_DECIDE = 2'b11
   } seq_t;
endpackage : wake_timer_pkg
